// ===== design/retimer_csr.sv
// CSR slice of a four-lane retimer: HS edge-rate, swing, pre-emphasis, contention flags
// and the bus-turnaround timeout timer.
// Assumes a classic Wishbone master, straps held stable around reset release, and a
// one-cycle low-power transmit clock enable pulse from a divider elsewhere.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps

module retimer_csr
  import retimer_csr_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       reset_in_low_active,
  input  wire retimer_csr_pkg::strap_s    straps,
  input  wire retimer_csr_pkg::conflict_s lane0_conflict,
  input  wire logic                       low_power_transmit,
  input  wire logic                       turnaround_request,
  input  wire logic                       turnaround_ack,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  output logic      [7:0]                 hs_lane_edge_rate,
  output logic      [1:0]                 hs_swing_select,
  output logic      [1:0]                 hs_emphasis_select,
  output logic                            turnaround_abandon,
  output logic                            turnaround_active
);
  import retimer_csr_pkg::*;

  typedef enum logic [1:0] {
    TA_IDLE,
    TA_RUN,
    TA_DONE
  } ta_state_e;

  function automatic logic [1:0] strap_code(input strap_level_e lvl);
    case (lvl)
      STRAP_LOW:  strap_code = 2'h0;
      STRAP_MID:  strap_code = 2'h1;
      STRAP_HIGH: strap_code = 2'h2;
      default:    strap_code = 2'h0;
    endcase
  endfunction

  // Register decode used by the unmapped-read check
  function automatic logic reg_mapped(input logic [7:0] adr);
    case (adr)
      OFF_HS_LANE_EDGE_RATE, OFF_LANE0_CONTENTION, OFF_HS_SWING_PREEMPH: reg_mapped = 1'b1;
      OFF_TURNAROUND_LOW, OFF_TURNAROUND_HIGH, OFF_TURNAROUND_STATUS:    reg_mapped = 1'b1;
      default:                                                           reg_mapped = 1'b0;
    endcase
  endfunction

  function automatic int slew_lsb(input int lane);
    case (lane)
      3:       slew_lsb = LANE3_SLEW_LSB;
      2:       slew_lsb = LANE2_SLEW_LSB;
      1:       slew_lsb = LANE1_SLEW_LSB;
      default: slew_lsb = LANE0_SLEW_LSB;
    endcase
  endfunction

  logic [7:0]  edge_q;
  logic [1:0]  swing_q;
  logic [1:0]  emph_q;
  logic [7:0]  limit_low_q;
  logic [7:0]  limit_high_q;
  conflict_s   conflict_q;
  logic        reset_in_low_active_prev_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] count_q;
  logic        abandon_q;
  logic        acked_q;
  ta_state_e   ta_q;

  // Strap capture on the rising edge of the pin reset
  wire         strap_load = reset_in_low_active & ~reset_in_low_active_prev_q;
  wire         bus_req    = wb_cyc_i & wb_stb_i & ~ack_q;
  wire         bus_wr     = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0]   wbyte      = wb_dat_i[7:0];
  wire         wr_edge    = bus_wr & (wb_adr_i == OFF_HS_LANE_EDGE_RATE);
  wire         wr_swing   = bus_wr & (wb_adr_i == OFF_HS_SWING_PREEMPH);
  wire         wr_low     = bus_wr & (wb_adr_i == OFF_TURNAROUND_LOW);
  wire         wr_high    = bus_wr & (wb_adr_i == OFF_TURNAROUND_HIGH);
  wire [1:0]   slew_code  = strap_code(straps.slew);
  wire [15:0]  limit      = {limit_high_q, limit_low_q};
  wire         expired    = (ta_q == TA_RUN) & (count_q >= limit);

  // Swing: mid first strap, or low first with second not high, gives 01
  wire         swing_up   = (straps.first_cfg == STRAP_HIGH) |
                            ((straps.first_cfg == STRAP_LOW) & (straps.second_cfg == STRAP_HIGH));
  wire [1:0]   swing_strap = swing_up ? SWING_HIGH_CODE : SWING_MID_CODE;
  wire [1:0]   emph_strap  = (straps.second_cfg == STRAP_HIGH) ? EMPHASIS_HIGH_CODE : EMPHASIS_MID_CODE;

  wire [7:0]   status_byte = {2'h0, conflict_q.out_neg, conflict_q.out_pos,
                              2'h0, conflict_q.in_neg, conflict_q.in_pos};
  wire [7:0]   swing_byte  = {2'h0, swing_q, 2'h0, emph_q};
  wire [7:0]   ta_byte     = {6'h00, abandon_q, acked_q};

  logic [7:0] rbyte;
  always_comb begin
    case (wb_adr_i)
      OFF_HS_LANE_EDGE_RATE: rbyte = edge_q;
      OFF_LANE0_CONTENTION:  rbyte = status_byte;
      OFF_HS_SWING_PREEMPH:  rbyte = swing_byte;
      OFF_TURNAROUND_LOW:    rbyte = limit_low_q;
      OFF_TURNAROUND_HIGH:   rbyte = limit_high_q;
      OFF_TURNAROUND_STATUS: rbyte = ta_byte;
      default:               rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_in_low_active_prev_q <= 1'b0;
    end else begin
      reset_in_low_active_prev_q <= reset_in_low_active;
    end
  end

  // Strap load takes priority so a stale write cannot survive power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_q  <= 8'h00;
      swing_q <= 2'h0;
      emph_q  <= 2'h0;
    end else if (strap_load) begin
      edge_q  <= {4{slew_code}};
      swing_q <= swing_strap;
      emph_q  <= emph_strap;
    end else begin
      if (wr_edge) begin
        edge_q <= wbyte;
      end
      if (wr_swing) begin
        swing_q <= wbyte[SWING_LSB +: 2];
        emph_q  <= wbyte[EMPHASIS_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      limit_low_q  <= TURNAROUND_BYTE_RESET;
      limit_high_q <= TURNAROUND_BYTE_RESET;
    end else begin
      if (wr_low) begin
        limit_low_q <= wbyte;
      end
      if (wr_high) begin
        limit_high_q <= wbyte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conflict_q <= '0;
    end else begin
      conflict_q <= lane0_conflict;
    end
  end

  // One-cycle ack; the gap term stops a held request from being acked in two consecutive cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= bus_req;
      rdata_q <= bus_req ? {24'h000000, rbyte} : 32'h0000_0000;
    end
  end

  // Turnaround timer; a new request restarts even a running timer
  always_ff @(posedge clk) begin
    if (rst) begin
      ta_q      <= TA_IDLE;
      count_q   <= 16'h0000;
      abandon_q <= 1'b0;
      acked_q   <= 1'b0;
    end else if (turnaround_request) begin
      ta_q      <= TA_RUN;
      count_q   <= 16'h0000;
      abandon_q <= 1'b0;
      acked_q   <= 1'b0;
    end else begin
      case (ta_q)
        TA_IDLE: begin
          ta_q <= TA_IDLE;
        end
        TA_RUN: begin
          if (turnaround_ack) begin
            ta_q    <= TA_DONE;
            acked_q <= 1'b1;
          end else if (expired) begin
            ta_q      <= TA_DONE;
            abandon_q <= 1'b1;
          end else if (low_power_transmit) begin
            count_q <= count_q + 16'h0001;
          end
        end
        TA_DONE: begin
          ta_q <= TA_DONE;
        end
        default: begin
          ta_q <= TA_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o           = ack_q;
  assign wb_dat_o           = rdata_q;
  assign hs_lane_edge_rate  = edge_q;
  assign hs_swing_select    = swing_q;
  assign hs_emphasis_select = emph_q;
  assign turnaround_abandon = abandon_q;
  assign turnaround_active  = (ta_q == TA_RUN);

  sequence s_run_no_ack;
    (ta_q == TA_RUN) && !turnaround_ack && !turnaround_request;
  endsequence

  a_strap_slew_load: assert property (@(posedge clk) disable iff (rst)
    strap_load |=> edge_q == {4{$past(slew_code)}})
    else $error("edge rate not loaded from strap");
  a_strap_swing_load: assert property (@(posedge clk) disable iff (rst)
    strap_load |=> swing_q == $past(swing_strap))
    else $error("swing not loaded from straps");
  a_strap_emph_load: assert property (@(posedge clk) disable iff (rst)
    strap_load && straps.second_cfg == STRAP_HIGH |=> emph_q == EMPHASIS_HIGH_CODE)
    else $error("emphasis not high for high strap");
  a_edge_write: assert property (@(posedge clk) disable iff (rst)
    wr_edge && !strap_load |=> edge_q == $past(wbyte))
    else $error("edge rate write lost");
  a_swing_reserved: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(wb_adr_i) == OFF_HS_SWING_PREEMPH |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:2] == 2'h0)
    else $error("reserved bits not zero");
  a_conflict_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 status_byte[OUT_NEG_CONFLICT_BIT] == $past(lane0_conflict.out_neg))
    else $error("contention flag stale");
  a_req_restart: assert property (@(posedge clk) disable iff (rst)
    turnaround_request |=> ta_q == TA_RUN && count_q == 16'h0000 && !abandon_q)
    else $error("request did not restart timer");
  a_ack_halts: assert property (@(posedge clk) disable iff (rst)
    (ta_q == TA_RUN) && turnaround_ack && !turnaround_request |=>
      ta_q == TA_DONE && !abandon_q ##1 ($stable(count_q) || $past(turnaround_request)))
    else $error("ack did not halt timer");
  a_expire_abandon: assert property (@(posedge clk) disable iff (rst)
    s_run_no_ack and (count_q >= limit) |=> abandon_q)
    else $error("expired turnaround not abandoned");
  a_count_on_lp: assert property (@(posedge clk) disable iff (rst)
    s_run_no_ack and (count_q < limit) and !low_power_transmit |=> $stable(count_q))
    else $error("counter moved without lp clock");
  a_bus_ack_once: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Bus handshake and read word shape
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_word;
    wb_ack_o ##0 (wb_dat_o[31:8] == 24'h000000);
  endsequence

  a_bus_ack_next: assert property (@(posedge clk) disable iff (rst)
    s_bus_take |=> s_ack_word)
    else $error("request not acked after one cycle");
  a_status_reserved: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(wb_adr_i) == OFF_LANE0_CONTENTION |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:2] == 2'h0)
    else $error("status reserved bits not zero");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && !reg_mapped($past(wb_adr_i)) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped address read nonzero");
  a_ta_status_read: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(wb_adr_i) == OFF_TURNAROUND_STATUS |->
      wb_dat_o[7:0] == {6'h00, $past(abandon_q), $past(acked_q)})
    else $error("turnaround status read wrong");
  a_conflict_outputs: assert property (@(posedge clk) disable iff (rst)
    ##1 status_byte[OUT_NEG_CONFLICT_BIT -: 2] == $past(lane0_conflict[3:2]))
    else $error("output contention flags stale");
  a_conflict_inputs: assert property (@(posedge clk) disable iff (rst)
    ##1 status_byte[IN_NEG_CONFLICT_BIT -: 2] == $past(lane0_conflict[1:0]))
    else $error("input contention flags stale");

  // Strap loads, field writes and holds
  a_strap_swing_mid: assert property (@(posedge clk) disable iff (rst)
    strap_load && straps.first_cfg == STRAP_MID |=> swing_q == SWING_MID_CODE)
    else $error("swing not mid for mid strap");
  a_strap_emph_mid: assert property (@(posedge clk) disable iff (rst)
    strap_load && straps.second_cfg != STRAP_HIGH |=> emph_q == EMPHASIS_MID_CODE)
    else $error("emphasis not mid for low or mid strap");
  a_swing_write: assert property (@(posedge clk) disable iff (rst)
    wr_swing && !strap_load |=> swing_q == $past(wbyte[SWING_LSB +: 2]))
    else $error("swing write lost");
  a_emph_write: assert property (@(posedge clk) disable iff (rst)
    wr_swing && !strap_load |=> emph_q == $past(wbyte[EMPHASIS_LSB +: 2]))
    else $error("emphasis write lost");
  a_limit_low_write: assert property (@(posedge clk) disable iff (rst)
    wr_low |=> limit_low_q == $past(wbyte))
    else $error("timeout low byte write lost");
  a_limit_high_write: assert property (@(posedge clk) disable iff (rst)
    wr_high |=> limit_high_q == $past(wbyte))
    else $error("timeout high byte write lost");
  a_limit_hold: assert property (@(posedge clk) disable iff (rst)
    !wr_low && !wr_high |=> $stable(limit))
    else $error("timeout changed without write");
  a_edge_hold: assert property (@(posedge clk) disable iff (rst)
    !strap_load && !wr_edge |=> $stable(edge_q))
    else $error("edge rate changed without load or write");
  a_setting_hold: assert property (@(posedge clk) disable iff (rst)
    !strap_load && !wr_swing |=> $stable(swing_q) && $stable(emph_q))
    else $error("swing or emphasis changed without load or write");

  // Turnaround timer
  a_restart_clears: assert property (@(posedge clk) disable iff (rst)
    turnaround_request |=> !acked_q && turnaround_active)
    else $error("request did not clear acknowledge");
  a_abandon_hold: assert property (@(posedge clk) disable iff (rst)
    abandon_q && !turnaround_request |=> abandon_q)
    else $error("abandon flag dropped early");
  a_idle_frozen: assert property (@(posedge clk) disable iff (rst)
    (ta_q != TA_RUN) && !turnaround_request |=> $stable(count_q) && (ta_q != TA_RUN))
    else $error("stopped timer moved");
  a_no_early_abandon: assert property (@(posedge clk) disable iff (rst)
    s_run_no_ack and (count_q < limit) |=> !abandon_q && (ta_q == TA_RUN))
    else $error("turnaround abandoned before limit");
  a_ack_recorded: assert property (@(posedge clk) disable iff (rst)
    (ta_q == TA_RUN) && turnaround_ack && !turnaround_request |=> acked_q && !turnaround_active)
    else $error("acknowledge not recorded");
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    s_run_no_ack and (count_q < limit) and low_power_transmit |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter missed lp tick");

  // Per-lane slew fields
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    localparam int FIELD_LSB = slew_lsb(lane);
    a_lane_strap: assert property (@(posedge clk) disable iff (rst)
      strap_load |=> edge_q[FIELD_LSB +: 2] == $past(slew_code))
      else $error("lane slew not loaded from strap");
    a_lane_write: assert property (@(posedge clk) disable iff (rst)
      wr_edge && !strap_load |=> edge_q[FIELD_LSB +: 2] == $past(wbyte[FIELD_LSB +: 2]))
      else $error("lane slew write lost");
    a_lane_code: assert property (@(posedge clk) disable iff (rst)
      strap_load |=> edge_q[FIELD_LSB +: 2] != 2'h3)
      else $error("strap produced software-only slew code");
  end

endmodule

// ===== design/retimer_csr_pkg.sv
// Register map, field layout, reset values and strap codes of the retimer CSR slice.
// Assumes a byte-wide register file reached over a 32-bit classic Wishbone port.
package retimer_csr_pkg;

  localparam logic [7:0] OFF_HS_LANE_EDGE_RATE   = 8'h0B;
  localparam logic [7:0] OFF_LANE0_CONTENTION    = 8'h0D;
  localparam logic [7:0] OFF_HS_SWING_PREEMPH    = 8'h0E;
  localparam logic [7:0] OFF_TURNAROUND_LOW      = 8'h10;
  localparam logic [7:0] OFF_TURNAROUND_HIGH     = 8'h11;
  localparam logic [7:0] OFF_TURNAROUND_STATUS   = 8'h12;

  localparam int         LANE3_SLEW_LSB          = 6;
  localparam int         LANE2_SLEW_LSB          = 4;
  localparam int         LANE1_SLEW_LSB          = 2;
  localparam int         LANE0_SLEW_LSB          = 0;
  localparam int         OUT_NEG_CONFLICT_BIT    = 5;
  localparam int         OUT_POS_CONFLICT_BIT    = 4;
  localparam int         IN_NEG_CONFLICT_BIT     = 1;
  localparam int         IN_POS_CONFLICT_BIT     = 0;
  localparam int         SWING_LSB               = 4;
  localparam int         EMPHASIS_LSB            = 0;

  localparam logic [7:0] TURNAROUND_BYTE_RESET   = 8'hFF;
  localparam logic [1:0] SWING_MID_CODE          = 2'h1;
  localparam logic [1:0] SWING_HIGH_CODE         = 2'h2;
  localparam logic [1:0] EMPHASIS_MID_CODE       = 2'h1;
  localparam logic [1:0] EMPHASIS_HIGH_CODE      = 2'h2;

  // Three-level strap sample as delivered by the pin comparators
  typedef enum logic [1:0] {
    STRAP_LOW  = 2'h0,
    STRAP_MID  = 2'h1,
    STRAP_HIGH = 2'h2
  } strap_level_e;

  typedef struct packed {
    strap_level_e slew;
    strap_level_e first_cfg;
    strap_level_e second_cfg;
  } strap_s;

  typedef struct packed {
    logic out_neg;
    logic out_pos;
    logic in_neg;
    logic in_pos;
  } conflict_s;

endpackage

// ===== tb/tb.sv
// Self-checking bench for the retimer CSR slice and turnaround timer.
// Assumes one 125 MHz clock and the partner model for the LP side.
`timescale 1ns/1ps
module tb;
  import retimer_csr_pkg::*;
  logic        clk = 0, rst = 1, rin = 0, req = 0, ack_en = 0;
  logic        cyc = 0, stb = 0, we = 0, lp, ack, wack, aband, active;
  logic [3:0]  ack_ticks = 4'h0, sel = 4'h0;
  logic [7:0]  adr = 8'h00, edge_rate;
  logic [31:0] dwr = 32'h0, drd;
  logic [1:0]  swing, emph;
  conflict_s   conf = '0;
  strap_s      straps = '{STRAP_LOW, STRAP_LOW, STRAP_LOW};
  int          failures = 0, cmp_count = 0;
  always #4 clk = ~clk;
  retimer_csr dut_u (.clk(clk), .rst(rst), .reset_in_low_active(rin), .straps(straps),
    .lane0_conflict(conf), .low_power_transmit(lp), .turnaround_request(req),
    .turnaround_ack(ack), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(wack),
    .hs_lane_edge_rate(edge_rate), .hs_swing_select(swing), .hs_emphasis_select(emph),
    .turnaround_abandon(aband), .turnaround_active(active));
  turnaround_partner partner_u (.clk(clk), .rst(rst), .req(req), .ack_en(ack_en),
    .ack_ticks(ack_ticks), .lp_tick(lp), .ack(ack));
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled; the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, d, input logic [3:0] s, output logic [7:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dwr <= {24'h0, d};
    do @(posedge clk); while (wack !== 1'b1);
    r = drd[7:0];
    cmp8(drd[31:24] | drd[23:16] | drd[15:8], 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [3:0] s = 4'hF);
    logic [7:0] r;
    wb(1'b1, a, d, s, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, 4'hF, r);
    cmp8(r, exp);
  endtask
  task automatic do_reset(input strap_s s);
    rst    <= 1'b1;
    rin    <= 1'b0;
    straps <= s;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rin <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_straps(input logic [7:0] e0b, e0e);
    rd_chk(OFF_HS_LANE_EDGE_RATE, e0b);
    rd_chk(OFF_HS_SWING_PREEMPH, e0e);
    rd_chk(OFF_LANE0_CONTENTION, 8'h00);
    rd_chk(OFF_TURNAROUND_LOW, 8'hFF);
    rd_chk(OFF_TURNAROUND_HIGH, 8'hFF);
    cmp8(edge_rate, e0b);
    cmp8({2'h0, swing, 2'h0, emph}, e0e);
  endtask
  task automatic t_write;
    wr(OFF_HS_LANE_EDGE_RATE, 8'hFF);
    straps <= '{STRAP_LOW, STRAP_LOW, STRAP_LOW};
    rd_chk(OFF_HS_LANE_EDGE_RATE, 8'hFF);
    cmp8(edge_rate, 8'hFF);
    wr(OFF_HS_SWING_PREEMPH, 8'hFF);
    rd_chk(OFF_HS_SWING_PREEMPH, 8'h33);
    cmp8({2'h0, swing, 2'h0, emph}, 8'h33);
    wr(OFF_LANE0_CONTENTION, 8'hFF);
    rd_chk(OFF_LANE0_CONTENTION, 8'h00);
    rd_chk(8'h20, 8'h00);
  endtask
  task automatic t_conflict;
    conf <= '{1'b1, 1'b0, 1'b0, 1'b1};
    rd_chk(OFF_LANE0_CONTENTION, 8'h21);
    conf <= '{1'b0, 1'b1, 1'b1, 1'b0};
    rd_chk(OFF_LANE0_CONTENTION, 8'h12);
    conf <= '0;
  endtask
  // Counts LP ticks seen while the timer runs, until it stops
  task automatic bta(input logic en, input logic [3:0] n, input logic [7:0] exp_t, input logic exp_ab);
    int k;
    logic [7:0] t;
    ack_en    <= en;
    ack_ticks <= n;
    req       <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    t = 0;
    // Old abandon flag still shows at the request edge, so the first cycles always run
    for (k = 0; k < 200 && (k < 3 || (aband !== 1'b1 && active === 1'b1)); k++) begin
      @(posedge clk);
      if (lp === 1'b1 && active === 1'b1)
        t++;
    end
    @(posedge clk);
    cmp8(t, exp_t);
    cmp1(aband, exp_ab);
    cmp1(active, 1'b0);
  endtask
  task automatic t_timer;
    wr(OFF_TURNAROUND_LOW, 8'h03);
    wr(OFF_TURNAROUND_HIGH, 8'h00);
    wr(OFF_TURNAROUND_HIGH, 8'h07, 4'hE);
    rd_chk(OFF_TURNAROUND_HIGH, 8'h00);
    bta(1'b0, 4'h0, 8'h03, 1'b1);
    rd_chk(OFF_TURNAROUND_STATUS, 8'h02);
    bta(1'b1, 4'h2, 8'h02, 1'b0);
    rd_chk(OFF_TURNAROUND_STATUS, 8'h01);
    repeat (40) @(posedge clk);
    cmp1(aband, 1'b0);
    // Partner kept silent so the restart hits a running timer
    ack_en <= 1'b0;
    req    <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (6) @(posedge clk);
    cmp1(active, 1'b1);
    bta(1'b0, 4'h0, 8'h03, 1'b1);
  endtask
  initial begin
    do_reset('{STRAP_MID, STRAP_MID, STRAP_LOW});
    t_straps(8'h55, 8'h11);
    do_reset('{STRAP_HIGH, STRAP_LOW, STRAP_HIGH});
    t_straps(8'hAA, 8'h22);
    do_reset('{STRAP_LOW, STRAP_LOW, STRAP_MID});
    t_straps(8'h00, 8'h11);
    do_reset('{STRAP_LOW, STRAP_HIGH, STRAP_LOW});
    t_straps(8'h00, 8'h21);
    t_write;
    t_conflict;
    t_timer;
    report_and_stop;
  end
  // Tests need well under 2000 cycles; this is a wide margin
  initial begin
    #100us;
    failures++;
    report_and_stop;
  end
endmodule

// ===== tb/turnaround_partner.sv
// Far-side model: LP transmit clock tick source and turnaround acknowledger.
// Assumes the bench sets ack_en and ack_ticks in the cycle it raises req.
`timescale 1ns/1ps
module turnaround_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_ticks,
  output logic            lp_tick,
  output logic            ack
);
  logic [1:0] div_q;
  logic [3:0] seen_q;
  logic       armed_q;
  always_ff @(posedge clk) begin
    div_q   <= rst ? 2'h0 : div_q + 2'h1;
    lp_tick <= !rst && div_q == 2'h3;
    ack     <= 1'b0;
    if (rst || req) begin
      armed_q <= !rst && ack_en;
      seen_q  <= 4'h0;
    end else if (armed_q && lp_tick) begin
      seen_q <= seen_q + 4'h1;
      // Silent unless told to answer, so expiry can be provoked
      if (seen_q + 4'h1 == ack_ticks) begin
        ack     <= 1'b1;
        armed_q <= 1'b0;
      end
    end
  end
endmodule
